// ===== verilog/debug_control_status_regs.sv
// debug control and status registers of the on-chip debugger
// assumes the host byte path is already deserialised, the cpu core
// reports opcode decodes and pc, all on one system clock
`timescale 1ns/1ps
module debug_control_status_regs
   import dbg_regs_pkg::*;
(
   // clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESET_N_I,
   // host command bytes
   input  wire logic        HOST_RX_VALID_I,
   input  wire logic [7:0]  HOST_RX_DATA_I,
   input  wire logic        HOST_TX_READY_I,
   output logic             HOST_TX_VALID_O,
   output logic [7:0]       HOST_TX_DATA_O,
   // cpu core
   input  wire logic        CPU_DECODE_I,
   input  wire logic [7:0]  CPU_OPCODE_I,
   input  wire logic [15:0] CPU_PC_I,
   input  wire logic        CPU_HALT_I,
   output logic             CPU_STOP_O,
   output logic             CPU_BRK_NOP_O,
   output logic             CPU_BRK_LOOP_O,
   // chip reset
   output logic             CHIP_RESET_O,
   input  wire logic        CHIP_RESET_DONE_I,
   // option bit and counter access
   input  wire logic        RP_OPTION_I,
   input  wire logic        CNT_LOAD_I,
   input  wire logic [15:0] CNT_DATA_I,
   output logic [15:0]      CNT_VALUE_O
);

   // ==========================================================
   // declarations
   cmd_state_t  state_ff;
   cmd_state_t  nxt_state;
   logic        dbg_ff, nxt_dbg;
   logic        brk_en_ff, ack_en_ff, loop_ff;
   logic        pc_brk_ff, zero_brk_ff, rst_ff;
   logic        seen_ff;
   logic        resp_pend_ff, ack_pend_ff, tx_valid_ff;
   logic [7:0]  resp_byte_ff, tx_data_ff;
   logic [7:0]  ctl_val, stat_val;
   logic        ctl_wr, rp_on, running, brk_hit, brk_stop;
   logic        brk_loop_hit, pc_hit, zero_hit, hw_set, brk_evt;
   logic        tx_free, leave_dbg;
   logic [15:0] cnt;

   // true when the byte names a read command
   function automatic logic is_read_cmd(input logic [7:0] b);
      is_read_cmd = (b == CMD_RD_STAT) || (b == CMD_RD_CTL);
   endfunction

   // true when the byte is the break opcode
   function automatic logic is_brk(input logic [7:0] b);
      is_brk = (b == BRK_OPCODE);
   endfunction

   // ==========================================================
   // command decoder
   assign ctl_wr = (state_ff == CMD_WDATA) && HOST_RX_VALID_I;

   // next command state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         CMD_IDLE: begin
            if (HOST_RX_VALID_I && HOST_RX_DATA_I == CMD_WR_CTL) begin
               nxt_state = CMD_WDATA;
            end
         end
         CMD_WDATA: begin
            if (HOST_RX_VALID_I) begin
               nxt_state = CMD_IDLE;
            end
         end
         default: nxt_state = CMD_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         state_ff <= CMD_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // cpu side events
   assign rp_on    = !RP_OPTION_I;
   assign running  = !dbg_ff && !CPU_HALT_I && !rst_ff;
   assign brk_hit  = CPU_DECODE_I && is_brk(CPU_OPCODE_I)
                     && brk_en_ff;
   assign brk_stop     = brk_hit && !loop_ff;
   assign brk_loop_hit = brk_hit && loop_ff;
   assign pc_hit   = pc_brk_ff && running && CPU_PC_I == cnt;
   assign hw_set   = brk_stop || pc_hit
                     || (zero_hit && zero_brk_ff);
   assign brk_evt  = hw_set || (brk_loop_hit && !seen_ff);

   // ==========================================================
   // debug mode flag: hardware set wins over a clearing write
   always_comb begin
      nxt_dbg = dbg_ff;
      if (ctl_wr) begin
         nxt_dbg = HOST_RX_DATA_I[CTL_DBG_BIT]
                   || (rp_on && dbg_ff);
      end
      if (hw_set) begin
         nxt_dbg = 1'b1;
      end
   end

   // debug mode survives the chip reset it requests
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         dbg_ff <= 1'b0;
      end else begin
         dbg_ff <= nxt_dbg;
      end
   end

   // ==========================================================
   // plain control fields, loaded from each control write
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         brk_en_ff   <= CTL_RST_VAL[CTL_BRK_BIT];
         ack_en_ff   <= CTL_RST_VAL[CTL_ACK_BIT];
         loop_ff     <= CTL_RST_VAL[CTL_LOOP_BIT];
         pc_brk_ff   <= CTL_RST_VAL[CTL_PC_BIT];
         zero_brk_ff <= CTL_RST_VAL[CTL_ZERO_BIT];
      end else if (ctl_wr) begin
         brk_en_ff   <= HOST_RX_DATA_I[CTL_BRK_BIT];
         ack_en_ff   <= HOST_RX_DATA_I[CTL_ACK_BIT];
         loop_ff     <= HOST_RX_DATA_I[CTL_LOOP_BIT];
         pc_brk_ff   <= HOST_RX_DATA_I[CTL_PC_BIT];
         zero_brk_ff <= HOST_RX_DATA_I[CTL_ZERO_BIT];
      end
   end

   // ==========================================================
   // reset bit: set by a write of one, cleared when chip reset ends
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         rst_ff <= CTL_RST_VAL[CTL_RST_BIT];
      end else if (ctl_wr && HOST_RX_DATA_I[CTL_RST_BIT]) begin
         rst_ff <= 1'b1;
      end else if (CHIP_RESET_DONE_I) begin
         rst_ff <= 1'b0;
      end
   end

   // ==========================================================
   // break seen since the last control write; a break wins
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         seen_ff <= 1'b0;
      end else if (brk_hit) begin
         seen_ff <= 1'b1;
      end else if (ctl_wr) begin
         seen_ff <= 1'b0;
      end
   end

   // ==========================================================
   // debug counter
   // only a write clears debug mode, so the zero break bit being written
   // decides whether the loaded count survives the step out of debug mode
   assign leave_dbg = dbg_ff && !nxt_dbg;

   dbg_down_counter u_cnt (
      .clk_i       (CORE_CLK_I),
      .rst_n_i     (RESET_N_I),
      .load_i      (CNT_LOAD_I && dbg_ff),
      .load_data_i (CNT_DATA_I),
      .count_en_i  (running && !pc_brk_ff),
      .restore_i   (leave_dbg && !HOST_RX_DATA_I[CTL_ZERO_BIT]),
      .count_o     (cnt),
      .zero_hit_o  (zero_hit)
   );

   // ==========================================================
   // register images
   assign ctl_val = {dbg_ff, brk_en_ff, ack_en_ff, loop_ff,
                     pc_brk_ff, zero_brk_ff, 1'b0, rst_ff};
   assign stat_val = {dbg_ff || seen_ff,
                      CPU_HALT_I,
                      rp_on,
                      STAT_RSV_VAL};

   // ==========================================================
   // pending read answer, captured when the read command arrives
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         resp_pend_ff <= 1'b0;
         resp_byte_ff <= 8'h00;
      end else if (state_ff == CMD_IDLE && HOST_RX_VALID_I
                   && is_read_cmd(HOST_RX_DATA_I)) begin
         resp_pend_ff <= 1'b1;
         resp_byte_ff <= (HOST_RX_DATA_I == CMD_RD_STAT)
                         ? stat_val : ctl_val;
      end else if (tx_free) begin
         resp_pend_ff <= 1'b0;
      end
   end

   // pending acknowledge; a new break wins over the take
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         ack_pend_ff <= 1'b0;
      end else if (brk_evt && ack_en_ff) begin
         ack_pend_ff <= 1'b1;
      end else if (tx_free && !resp_pend_ff) begin
         ack_pend_ff <= 1'b0;
      end
   end

   // ==========================================================
   // transmit holding stage; read answers go before acknowledges
   assign tx_free = !tx_valid_ff || HOST_TX_READY_I;

   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         tx_valid_ff <= 1'b0;
         tx_data_ff  <= 8'h00;
      end else if (tx_free) begin
         tx_valid_ff <= resp_pend_ff || ack_pend_ff;
         tx_data_ff  <= resp_pend_ff ? resp_byte_ff : ACK_BYTE;
      end
   end

   // ==========================================================
   // outputs
   assign HOST_TX_VALID_O = tx_valid_ff;
   assign HOST_TX_DATA_O  = tx_data_ff;
   assign CPU_STOP_O      = dbg_ff;
   assign CPU_BRK_NOP_O   = !brk_en_ff;
   assign CPU_BRK_LOOP_O  = brk_en_ff && loop_ff;
   assign CHIP_RESET_O    = rst_ff;
   assign CNT_VALUE_O     = cnt;

   // ==========================================================
   // checks
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);

   chk_reset_stop: assert property (
      ctl_wr && HOST_RX_DATA_I == CTL_RESET_STOP
      |=> dbg_ff && rst_ff && CHIP_RESET_O)
      else $error("81h write did not stop and reset");

   chk_reset_go: assert property (
      ctl_wr && HOST_RX_DATA_I == CTL_RESET_GO && !rp_on && !hw_set
      |=> !CPU_STOP_O && CHIP_RESET_O && brk_en_ff)
      else $error("41h write did not reset and run");

   chk_run_resume: assert property (
      dbg_ff && ctl_wr && HOST_RX_DATA_I == CTL_RUN
      && !rp_on && !hw_set
      |=> !dbg_ff && brk_en_ff && !CPU_BRK_NOP_O)
      else $error("40h write did not resume");

   chk_rst_clear: assert property (
      rst_ff && CHIP_RESET_DONE_I
      && !(ctl_wr && HOST_RX_DATA_I[CTL_RST_BIT])
      |=> !CHIP_RESET_O)
      else $error("reset bit did not self clear");

   chk_rp_hold: assert property (
      rp_on && dbg_ff |=> dbg_ff)
      else $error("debug mode cleared under read protect");

   chk_brk_enter: assert property (
      CPU_DECODE_I && CPU_OPCODE_I == BRK_OPCODE
      && brk_en_ff && !loop_ff |=> CPU_STOP_O)
      else $error("enabled break did not enter debug");

   chk_brk_nop: assert property (
      !dbg_ff && !brk_en_ff && !ctl_wr && !pc_hit && !zero_hit
      |=> !dbg_ff && $stable(seen_ff))
      else $error("disabled break had an effect");

   chk_pc_hold: assert property (
      pc_brk_ff && running && !CNT_LOAD_I |=> $stable(cnt))
      else $error("counter moved in pc match mode");

   chk_pc_break: assert property (
      pc_brk_ff && running && CPU_PC_I == cnt |=> dbg_ff)
      else $error("pc match did not break");

   chk_zero_break: assert property (
      zero_hit && zero_brk_ff |=> dbg_ff && cnt == CNT_ZERO)
      else $error("zero count did not break");

   chk_count_step: assert property (
      running && !pc_brk_ff && cnt != CNT_ZERO
      |=> cnt == $past(cnt) - CNT_ONE)
      else $error("counter did not step by one");

   chk_idle_flag: assert property (
      brk_hit ##1 !ctl_wr |=> stat_val[STAT_IDLE_BIT])
      else $error("idle status lost after break");

   chk_ack_queue: assert property (
      brk_evt && ack_en_ff |=> ack_pend_ff)
      else $error("acknowledge not queued");

   chk_rd_status: assert property (
      state_ff == CMD_IDLE && HOST_RX_VALID_I
      && HOST_RX_DATA_I == CMD_RD_STAT
      |=> resp_pend_ff && resp_byte_ff[4:0] == STAT_RSV_VAL)
      else $error("status read not answered");

   cov_reset_stop: cover property (
      ctl_wr && HOST_RX_DATA_I == CTL_RESET_STOP);
   cov_reset_go: cover property (
      ctl_wr && HOST_RX_DATA_I == CTL_RESET_GO);
   cov_brk_ack: cover property (
      brk_stop && ack_en_ff ##[1:4] HOST_TX_VALID_O);
   cov_zero_stop: cover property (zero_hit && zero_brk_ff);

endmodule // debug_control_status_regs

// ===== inc/dbg_regs_pkg.sv
// constants shared by the debug control and status register logic
// assumes one 10 MHz system clock and a byte-wide host command path
package dbg_regs_pkg;

   // ==========================================================
   // host command bytes and answer bytes
   localparam logic [7:0] CMD_RD_STAT = 8'h02;
   localparam logic [7:0] CMD_WR_CTL  = 8'h04;
   localparam logic [7:0] CMD_RD_CTL  = 8'h05;
   localparam logic [7:0] ACK_BYTE    = 8'hff;
   localparam logic [7:0] BRK_OPCODE  = 8'h00;

   // ==========================================================
   // well known control values
   localparam logic [7:0] CTL_RESET_STOP = 8'h81;
   localparam logic [7:0] CTL_RESET_GO   = 8'h41;
   localparam logic [7:0] CTL_RUN        = 8'h40;

   // ==========================================================
   // debug_control field positions
   localparam int CTL_DBG_BIT  = 7;
   localparam int CTL_BRK_BIT  = 6;
   localparam int CTL_ACK_BIT  = 5;
   localparam int CTL_LOOP_BIT = 4;
   localparam int CTL_PC_BIT   = 3;
   localparam int CTL_ZERO_BIT = 2;
   localparam int CTL_RSV_BIT  = 1;
   localparam int CTL_RST_BIT  = 0;

   // ==========================================================
   // debug_status field positions and reset values
   localparam int STAT_IDLE_BIT = 7;
   localparam int STAT_HALT_BIT = 6;
   localparam int STAT_RP_BIT   = 5;
   localparam logic [4:0]  STAT_RSV_VAL = 5'h00;
   localparam logic [7:0]  CTL_RST_VAL  = 8'h00;
   localparam logic [15:0] CNT_RST_VAL  = 16'hffff;
   localparam logic [15:0] CNT_ZERO     = 16'h0000;
   localparam logic [15:0] CNT_ONE      = 16'h0001;

   // command decoder states
   typedef enum logic [0:0] {CMD_IDLE, CMD_WDATA} cmd_state_t;

endpackage

// ===== verilog/dbg_down_counter.sv
// 16-bit debug down counter used for cycle counting and breaks
// assumes the caller decides when it counts, holds or reloads
`timescale 1ns/1ps
module dbg_down_counter
   import dbg_regs_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // control
   input  wire logic        load_i,
   input  wire logic [15:0] load_data_i,
   input  wire logic        count_en_i,
   input  wire logic        restore_i,
   // state
   output logic [15:0]      count_o,
   output logic             zero_hit_o
);

   logic [15:0] count_ff;

   // ==========================================================
   // counter register
   // load beats restore, restore beats counting; stops at zero
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         count_ff <= CNT_RST_VAL;
      end else if (load_i) begin
         count_ff <= load_data_i;
      end else if (restore_i) begin
         count_ff <= CNT_RST_VAL;
      end else if (count_en_i && count_ff != CNT_ZERO) begin
         count_ff <= count_ff - CNT_ONE;
      end
   end

   // ==========================================================
   // outputs: the pulse marks the step from one down to zero
   assign count_o    = count_ff;
   assign zero_hit_o = count_en_i && !load_i && !restore_i
                       && count_ff == CNT_ONE;

endmodule // dbg_down_counter

// ===== tb/dbg_host_model.sv
// behavioural debug host that sends command bytes and takes answers
// assumes the block samples bytes on the rising edge of clk_i
`timescale 1ns/1ps
module dbg_host_model
   import dbg_regs_pkg::*;
(
   // clock
   input  wire logic       clk_i,
   // byte path
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   output logic            tx_ready_o
);
   int stall = 0; // idle cycles before an answer is taken

   // ==========================================================
   // byte sending, a released line shows the inverse value
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h00;
      tx_ready_o = 1'b0;
   end

   task automatic send(input logic [7:0] d);
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_data_o  = d;
   endtask

   task automatic idle();
      @(negedge clk_i);
      rx_valid_o = 1'b0;
      rx_data_o  = ~rx_data_o;
   endtask

   // ==========================================================
   // answers are taken at the edge that sees valid with ready
   task automatic take(output logic [7:0] d);
      d = 8'hxx;
      repeat (stall) @(negedge clk_i);
      tx_ready_o = 1'b1;
      for (int n = 0; n < 60; n++) begin
         @(posedge clk_i);
         if (tx_valid_i === 1'b1) begin
            d = tx_data_i;
            break;
         end
      end
      @(negedge clk_i);
      tx_ready_o = 1'b0;
   endtask

   // ==========================================================
   // control write and register reads
   task automatic wr_ctl(input logic [7:0] d);
      send(CMD_WR_CTL);
      send(d & 8'hfd);
      idle();
   endtask

   task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
      send(cmd);
      idle();
      take(d);
   endtask
endmodule // dbg_host_model

// ===== tb/tb.sv
// self-checking bench of the debug control and status registers
// assumes a host model on the byte path and a bench-driven cpu side
`timescale 1ns/1ps
module tb;
   import dbg_regs_pkg::*;
   logic        core_clk, reset_n, rx_valid, tx_ready, tx_valid;
   logic        cpu_decode, cpu_halt, cpu_stop, brk_nop, brk_loop;
   logic        chip_reset, reset_done, rp_option, cnt_load;
   logic [7:0]  rx_data, tx_data, cpu_opcode, b;
   logic [15:0] cpu_pc, cnt_data, cnt_value, v;
   logic [31:0] seed = 32'h03435b31;
   logic [31:0] r;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;

   // ==========================================================
   // design and host model
   debug_control_status_regs u_dut (
      .CORE_CLK_I(core_clk), .RESET_N_I(reset_n),
      .HOST_RX_VALID_I(rx_valid), .HOST_RX_DATA_I(rx_data),
      .HOST_TX_READY_I(tx_ready), .HOST_TX_VALID_O(tx_valid),
      .HOST_TX_DATA_O(tx_data), .CPU_DECODE_I(cpu_decode),
      .CPU_OPCODE_I(cpu_opcode), .CPU_PC_I(cpu_pc),
      .CPU_HALT_I(cpu_halt), .CPU_STOP_O(cpu_stop),
      .CPU_BRK_NOP_O(brk_nop), .CPU_BRK_LOOP_O(brk_loop),
      .CHIP_RESET_O(chip_reset), .CHIP_RESET_DONE_I(reset_done),
      .RP_OPTION_I(rp_option), .CNT_LOAD_I(cnt_load),
      .CNT_DATA_I(cnt_data), .CNT_VALUE_O(cnt_value));
   dbg_host_model u_host (
      .clk_i(core_clk), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data),
      .tx_ready_o(tx_ready));

   // ==========================================================
   // clock, cycle ceiling, expectation helpers
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [7:0] exp_stat(logic idle, logic h, logic o);
      return {idle, h, ~o, STAT_RSV_VAL};
   endfunction

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] e);
      u_host.rd(cmd, b);
      chk_val({8'h00, b}, {8'h00, e});
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // one decoded break opcode, or one reset-done pulse
   task automatic break_opcode();
      @(negedge core_clk);
      cpu_decode = 1'b1;
      cpu_opcode = BRK_OPCODE;
      @(negedge core_clk);
      cpu_decode = 1'b0;
      cpu_opcode = 8'h5a;
      step(1);
   endtask

   task automatic done_pulse();
      @(negedge core_clk);
      reset_done = 1'b1;
      @(negedge core_clk);
      reset_done = 1'b0;
      step(1);
   endtask

   task automatic load_cnt(input logic [15:0] d);
      @(negedge core_clk);
      cnt_load = 1'b1;
      cnt_data = d;
      @(negedge core_clk);
      cnt_load = 1'b0;
      cnt_data = ~d;
   endtask

   task automatic report_and_stop();
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {reset_n, cpu_decode, cpu_halt, reset_done, cnt_load} = 5'h00;
      {cpu_opcode, cpu_pc, cnt_data} = 40'h5a_0000_0000;
      rp_option = 1'b1;
      step(8);
      reset_n = 1'b1;
      chk_bit(brk_nop, 1'b1);
      chk_val(cnt_value, CNT_RST_VAL);
      rd_chk(CMD_RD_CTL, CTL_RST_VAL);
      rd_chk(CMD_RD_STAT, exp_stat(0, 0, 1));
      // random control values, stray bytes and a slow host
      repeat (12) begin
         r = rnd();
         u_host.stall = int'(r[9:8]);
         cpu_decode = r[10];
         cpu_opcode = r[31:24] | 8'h01;
         cpu_pc     = {1'b0, r[14:0]};
         cnt_data   = r[31:16];
         reset_done = r[11];
         u_host.send(r[23:16] | 8'h10);
         u_host.idle();
         u_host.wr_ctl(r[7:0] & 8'hfc);
         rd_chk(CMD_RD_CTL, r[7:0] & 8'hfc);
      end
      {cpu_decode, reset_done, cpu_pc} = 18'h00000;
      u_host.wr_ctl(8'h20);
      break_opcode();
      chk_bit(cpu_stop, 1'b0);
      chk_bit(tx_valid, 1'b0);
      u_host.wr_ctl(8'h60);
      chk_bit(brk_nop, 1'b0);
      break_opcode();
      chk_bit(cpu_stop, 1'b1);
      u_host.stall = 3;
      u_host.take(b);
      chk_val({8'h00, b}, {8'h00, ACK_BYTE});
      rd_chk(CMD_RD_STAT, exp_stat(1, 0, 1));
      u_host.wr_ctl(CTL_RUN);
      chk_bit(cpu_stop, 1'b0);
      chk_bit(brk_nop, 1'b0);
      rd_chk(CMD_RD_STAT, exp_stat(0, 0, 1));
      u_host.wr_ctl(8'h50);
      chk_bit(brk_loop, 1'b1);
      break_opcode();
      chk_bit(cpu_stop, 1'b0);
      chk_bit(tx_valid, 1'b0);
      rd_chk(CMD_RD_STAT, exp_stat(1, 0, 1));
      u_host.wr_ctl(8'h00);
      rd_chk(CMD_RD_STAT, exp_stat(0, 0, 1));
      repeat (4) begin
         r = rnd();
         cpu_halt = r[3];
         rp_option = r[4];
         rd_chk(CMD_RD_STAT, exp_stat(0, r[3], r[4]));
      end
      {cpu_halt, rp_option} = 2'b01;
      // read protection keeps debug mode on
      rp_option = 1'b0;
      u_host.wr_ctl(8'h80);
      u_host.wr_ctl(8'h00);
      chk_bit(cpu_stop, 1'b1);
      rp_option = 1'b1;
      u_host.wr_ctl(8'h80);
      // countdown to zero with zero break
      load_cnt(16'h0004);
      u_host.wr_ctl(8'h04);
      chk_bit(cpu_stop, 1'b0);
      chk_val(cnt_value, 16'h0004);
      step(1);
      chk_val(cnt_value, 16'h0003);
      step(5);
      chk_bit(cpu_stop, 1'b1);
      chk_val(cnt_value, CNT_ZERO);
      u_host.wr_ctl(8'h04);
      chk_val(cnt_value, CNT_ZERO);
      u_host.wr_ctl(8'h80);
      u_host.wr_ctl(8'h08);
      chk_val(cnt_value, CNT_RST_VAL);
      // program counter match
      u_host.wr_ctl(8'h80);
      r = rnd();
      v = r[15:0] & 16'h7fff | 16'h0100;
      load_cnt(v);
      cpu_pc = v ^ 16'h0001;
      u_host.wr_ctl(8'h0c);
      step(5);
      chk_val(cnt_value, v);
      chk_bit(cpu_stop, 1'b0);
      cpu_pc = v;
      step(2);
      chk_bit(cpu_stop, 1'b1);
      cpu_pc = 16'h0000;
      // chip reset with stop and with go
      u_host.wr_ctl(CTL_RESET_STOP);
      chk_bit(chip_reset, 1'b1);
      u_host.wr_ctl(8'h80);
      chk_bit(chip_reset, 1'b1);
      done_pulse();
      chk_bit(chip_reset, 1'b0);
      chk_bit(cpu_stop, 1'b1);
      rd_chk(CMD_RD_CTL, 8'h80);
      u_host.wr_ctl(CTL_RESET_GO);
      chk_bit(chip_reset, 1'b1);
      done_pulse();
      chk_bit(cpu_stop, 1'b0);
      chk_bit(brk_nop, 1'b0);
      rd_chk(CMD_RD_CTL, CTL_RUN);
      report_and_stop();
   end
endmodule // tb
